// ### src/srr_pkg.sv
// Shared constants and types for the serial register read link.
package srr_pkg;
	// Seven-bit bus address of the device; the value is arbitrary.
	localparam logic [6:0] SRR_SLAVE_ADDR = 7'h0D;
	localparam logic [7:0] SRR_CMD_BLK_RD = 8'hA1;
	localparam logic [7:0] SRR_CMD_PTR = 8'hB0;
	localparam logic [7:0] SRR_PTR_RST = 8'h00;
	localparam logic [7:0] SRR_CNT_RST = 8'h00;
	localparam logic [3:0] SRR_ACK_BIT = 4'h8;
	localparam logic [3:0] SRR_LAST_BIT = 4'h7;
	localparam int SRR_CLK_NS = 10;
	localparam int SRR_QTR_NS = 2500;
	localparam int SRR_QTR_CYC = (SRR_QTR_NS + SRR_CLK_NS - 1) / SRR_CLK_NS;
	localparam logic [7:0] SRR_QTR_LOAD = 8'(SRR_QTR_CYC - 1);
	typedef enum logic [1:0] {
		SRR_OP_PTR,
		SRR_OP_RBYTE,
		SRR_OP_RBLK
	} srr_op_t;
endpackage : srr_pkg

// ### src/srr_link_if.sv
// Two-wire link between the bus master end and the device end.
`timescale 1ns/1ps
interface srr_link_if;
	logic scl;
	logic sda;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;

	// Open-drain data line: low while either end drives a low, else pulled up.
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

	modport master (
		output scl,
		output sda_m_o,
		output sda_m_oe,
		input sda
	);

	modport slave (
		input scl,
		input sda,
		output sda_s_o,
		output sda_s_oe
	);
endinterface : srr_link_if

// ### src/srr_slave.sv
// Device end of the link: address pointer, pointer load and the two reads.
`timescale 1ns/1ps
module srr_slave
	import srr_pkg::*;
(
	srr_link_if.slave link,
	input wire logic rst_b,
	input wire logic clk_en,
	output logic [7:0] reg_addr,
	input wire logic [7:0] reg_data,
	output logic [7:0] blk_count,
	output logic active
);
	typedef enum logic [2:0] {
		D_IDLE,
		D_IGNORE,
		D_ADDR,
		D_CMD,
		D_ARG,
		D_RD,
		D_RACK
	} srr_dst_t;

	typedef struct packed {
		srr_dst_t st;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic ack;
		logic rd;
		logic arg_ptr;
		logic blk;
		logic [7:0] ptr;
		logic [7:0] cnt;
		logic sda_oe;
	} srr_dstate_t;

	srr_dstate_t s_r;
	srr_dstate_t s_nxt;
	logic sda_p_r;
	logic start;
	logic [7:0] sh_in;

	// Data is sampled on the rising edge; a fall between that and the
	// falling edge is a start. In idle any low at the falling edge counts,
	// because the stop before it leaves no rising edge to sample the high line.
	assign start = (sda_p_r && !link.sda) || (s_r.st == D_IDLE && !link.sda);
	assign sh_in = {s_r.sh[6:0], sda_p_r};

	always_comb begin
		s_nxt = s_r;
		if (start) begin
			s_nxt.st = D_ADDR;
			s_nxt.bitcnt = 4'h0;
			s_nxt.ack = 1'b0;
			s_nxt.sda_oe = 1'b0;
		end else begin
			unique case (s_r.st)
				D_IDLE, D_IGNORE: begin
				end
				D_ADDR, D_CMD, D_ARG: begin
					if (s_r.ack) begin
						s_nxt.ack = 1'b0;
						s_nxt.sda_oe = 1'b0;
						s_nxt.bitcnt = 4'h0;
						if (s_r.st == D_ADDR && s_r.rd) begin
							// Pointer location goes out first. [R1] [R11]
							s_nxt.st = D_RD;
							s_nxt.sh = {reg_data[6:0], 1'b0};
							s_nxt.sda_oe = !reg_data[7];
							s_nxt.bitcnt = 4'h1;
						end else if (s_r.st == D_ADDR) begin
							s_nxt.st = D_CMD;
						end else if (s_r.st == D_CMD) begin
							s_nxt.st = D_ARG;
						end else begin
							s_nxt.st = D_IDLE;
						end
					end else begin
						s_nxt.sh = sh_in;
						s_nxt.bitcnt = s_r.bitcnt + 4'h1;
						if (s_r.bitcnt == SRR_LAST_BIT) begin
							s_nxt.st = D_IGNORE;
							if (s_r.st == D_ADDR) begin
								if (sh_in[7:1] == SRR_SLAVE_ADDR) begin
									s_nxt.st = D_ADDR; // [R2] [R5] [R7]
									s_nxt.ack = 1'b1;
									s_nxt.rd = sh_in[0];
								end
							end else if (s_r.st == D_CMD) begin
								if (sh_in == SRR_CMD_BLK_RD) begin
									s_nxt.st = D_CMD; // [R5]
									s_nxt.ack = 1'b1;
									s_nxt.arg_ptr = 1'b0;
									s_nxt.blk = 1'b1;
								end else if (sh_in == SRR_CMD_PTR) begin
									s_nxt.st = D_CMD; // [R10]
									s_nxt.ack = 1'b1;
									s_nxt.arg_ptr = 1'b1;
									s_nxt.blk = 1'b0;
								end
							end else begin
								s_nxt.st = D_ARG;
								s_nxt.ack = 1'b1;
								if (s_r.arg_ptr) begin
									s_nxt.ptr = sh_in; // [R10]
								end else begin
									s_nxt.cnt = sh_in; // [R6]
								end
							end
							s_nxt.sda_oe = s_nxt.ack;
						end
					end
				end
				D_RD: begin
					if (s_r.bitcnt == SRR_ACK_BIT) begin
						s_nxt.sda_oe = 1'b0;
						s_nxt.st = D_RACK;
						if (s_r.blk) begin
							s_nxt.ptr = s_r.ptr + 8'h01; // [R11]
						end
					end else begin
						s_nxt.sda_oe = !s_r.sh[7]; // [R8]
						s_nxt.sh = {s_r.sh[6:0], 1'b0};
						s_nxt.bitcnt = s_r.bitcnt + 4'h1;
					end
				end
				D_RACK: begin
					if (!sda_p_r) begin
						s_nxt.st = D_RD; // [R8] [R11]
						s_nxt.sh = {reg_data[6:0], 1'b0};
						s_nxt.sda_oe = !reg_data[7];
						s_nxt.bitcnt = 4'h1;
					end else begin
						s_nxt.st = D_IDLE; // [R12]
						s_nxt.blk = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge link.scl or negedge rst_b) begin
		if (!rst_b) begin
			sda_p_r <= 1'b1;
		end else if (clk_en) begin
			sda_p_r <= link.sda;
		end
	end

	// Changes on the falling edge keep the data line still while the clock is high.
	always_ff @(negedge link.scl or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{st: D_IDLE, bitcnt: 4'h0, sh: 8'h00, ack: 1'b0, rd: 1'b0,
				arg_ptr: 1'b0, blk: 1'b0, ptr: SRR_PTR_RST, cnt: SRR_CNT_RST,
				sda_oe: 1'b0};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe = s_r.sda_oe;
	assign reg_addr = s_r.ptr;
	assign blk_count = s_r.cnt;
	assign active = (s_r.st != D_IDLE) && (s_r.st != D_IGNORE);
endmodule : srr_slave

// ### src/srr_master.sv
// Bus master end: sets the pointer and runs single and block reads.
`timescale 1ns/1ps

// Contract
// R1: Single read returns byte at held pointer.
// R2: Single read: start, address with read bit.
// R3: Master answers single byte with no-ack, stop.
// R4: Pointer must be set before block read.
// R5: Block read: address write, then command byte.
// R6: Count byte follows command, device acknowledges.
// R7: Repeated start, address with read bit, ack.
// R8: Master acknowledges every data byte but last.
// R9: Last block byte gets no-ack, then stop.
// R10: Pointer load: command byte then location byte.
// R11: Block read walks upward from pointer location.
// R12: On no-ack device releases line until start.
module srr_master
	import srr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	srr_link_if.master link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire srr_op_t cmd_op,
	input wire logic [7:0] cmd_arg,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic rd_last,
	output logic done,
	output logic nack_err,
	output logic busy
);
	typedef enum logic [3:0] {
		M_IDLE,
		M_START,
		M_ADDR,
		M_CMD,
		M_ARG,
		M_RSTART,
		M_RADDR,
		M_DATA,
		M_STOP
	} srr_step_t;

	typedef struct packed {
		srr_step_t step;
		logic [1:0] q;
		logic [7:0] qcnt;
		logic [3:0] bitn;
		logic [7:0] sh;
		srr_op_t op;
		logic [7:0] arg;
		logic [7:0] remain;
		logic ack_seen;
		logic scl;
		logic sda_oe;
		logic s1;
		logic s2;
		logic rd_valid;
		logic [7:0] rd_data;
		logic rd_last;
		logic done;
		logic err;
	} srr_mstate_t;

	srr_mstate_t s_r;
	srr_mstate_t s_nxt;
	logic is_read;
	logic let_go;

	// Only the data step receives; every other byte step sends.
	assign is_read = (s_r.step == M_DATA);
	// The line is let go as the clock falls, before the other end takes it,
	// so the two ends never pull it low together.
	assign let_go = is_read ? (s_r.bitn == SRR_ACK_BIT)
		: (s_r.bitn == SRR_LAST_BIT);

	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = link.sda;
		s_nxt.s2 = s_r.s1;
		s_nxt.rd_valid = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.err = 1'b0;
		if (s_r.step == M_IDLE) begin
			if (cmd_valid) begin
				s_nxt.op = cmd_op;
				s_nxt.arg = cmd_arg;
				// A zero count still reads one byte so the frame can close.
				s_nxt.remain = (cmd_arg == 8'h00) ? 8'h01 : cmd_arg;
				s_nxt.step = M_START;
				s_nxt.q = 2'h0;
				s_nxt.qcnt = SRR_QTR_LOAD;
				s_nxt.bitn = 4'h0;
			end
		end else if (s_r.qcnt != 8'h00) begin
			s_nxt.qcnt = s_r.qcnt - 8'h01;
		end else begin
			s_nxt.qcnt = SRR_QTR_LOAD;
			s_nxt.q = s_r.q + 2'h1;
			unique case (s_r.step)
				M_START, M_RSTART: begin
					unique case (s_r.q)
						2'h0: begin
							s_nxt.sda_oe = 1'b0;
						end
						2'h1: begin
							s_nxt.scl = 1'b1;
						end
						2'h2: begin
							s_nxt.sda_oe = 1'b1; // [R2] [R5] [R7]
						end
						2'h3: begin
							s_nxt.scl = 1'b0;
							s_nxt.bitn = 4'h0;
							if (s_r.step == M_START) begin
								s_nxt.step = M_ADDR;
								s_nxt.sh = {SRR_SLAVE_ADDR, s_r.op == SRR_OP_RBYTE}; // [R2] [R5]
							end else begin
								s_nxt.step = M_RADDR;
								s_nxt.sh = {SRR_SLAVE_ADDR, 1'b1}; // [R7]
							end
						end
					endcase
				end
				M_STOP: begin
					unique case (s_r.q)
						2'h0: begin
							s_nxt.sda_oe = 1'b1;
						end
						2'h1: begin
							s_nxt.scl = 1'b1;
						end
						2'h2: begin
							s_nxt.sda_oe = 1'b0; // [R3] [R9]
						end
						2'h3: begin
							s_nxt.step = M_IDLE;
							s_nxt.done = 1'b1;
						end
					endcase
				end
				default: begin
					unique case (s_r.q)
						2'h0: begin
							if (s_r.bitn != SRR_ACK_BIT) begin
								s_nxt.sda_oe = is_read ? 1'b0 : !s_r.sh[7];
							end else if (is_read) begin
								// Ack all but the last byte. [R3] [R8] [R9]
								s_nxt.sda_oe = (s_r.remain != 8'h01);
							end else begin
								s_nxt.sda_oe = 1'b0;
							end
						end
						2'h1: begin
							s_nxt.scl = 1'b1;
						end
						2'h2: begin
							if (s_r.bitn != SRR_ACK_BIT) begin
								s_nxt.sh = {s_r.sh[6:0], s_r.s2};
							end else begin
								s_nxt.ack_seen = !s_r.s2;
							end
						end
						2'h3: begin
							s_nxt.scl = 1'b0;
							if (let_go) begin
								s_nxt.sda_oe = 1'b0; // [R8]
							end
							if (s_r.bitn != SRR_ACK_BIT) begin
								s_nxt.bitn = s_r.bitn + 4'h1;
							end else begin
								s_nxt.bitn = 4'h0;
								if (!is_read && !s_r.ack_seen) begin
									// A refused byte ends the frame at once.
									s_nxt.step = M_STOP;
									s_nxt.err = 1'b1;
								end else begin
									unique case (s_r.step)
										M_ADDR: begin
											if (s_r.op == SRR_OP_RBYTE) begin
												s_nxt.step = M_DATA; // [R1] [R2]
											end else if (s_r.op == SRR_OP_PTR) begin
												s_nxt.step = M_CMD;
												s_nxt.sh = SRR_CMD_PTR; // [R10]
											end else begin
												s_nxt.step = M_CMD;
												s_nxt.sh = SRR_CMD_BLK_RD; // [R5]
											end
										end
										M_CMD: begin
											s_nxt.step = M_ARG;
											s_nxt.sh = s_r.arg; // [R6] [R10]
										end
										M_ARG: begin
											if (s_r.op == SRR_OP_PTR) begin
												s_nxt.step = M_STOP; // [R4] [R10]
											end else begin
												s_nxt.step = M_RSTART; // [R7]
											end
										end
										M_RADDR: begin
											s_nxt.step = M_DATA; // [R8]
										end
										M_DATA: begin
											s_nxt.rd_valid = 1'b1; // [R1] [R8]
											s_nxt.rd_data = s_r.sh;
											s_nxt.rd_last = (s_r.remain == 8'h01);
											if (s_r.remain == 8'h01) begin
												s_nxt.step = M_STOP; // [R3] [R9]
											end else begin
												s_nxt.remain = s_r.remain - 8'h01;
											end
										end
										default: begin
											s_nxt.step = M_STOP;
										end
									endcase
								end
							end
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '{step: M_IDLE, q: 2'h0, qcnt: 8'h00, bitn: 4'h0, sh: 8'h00,
				op: SRR_OP_PTR, arg: 8'h00, remain: 8'h00, ack_seen: 1'b0,
				scl: 1'b1, sda_oe: 1'b0, s1: 1'b1, s2: 1'b1, rd_valid: 1'b0,
				rd_data: 8'h00, rd_last: 1'b0, done: 1'b0, err: 1'b0};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// The clock is push-pull; the device never stretches it.
	assign link.scl = s_r.scl;
	assign link.sda_m_o = 1'b0;
	assign link.sda_m_oe = s_r.sda_oe;
	assign cmd_ready = (s_r.step == M_IDLE);
	assign busy = (s_r.step != M_IDLE);
	assign rd_valid = s_r.rd_valid;
	assign rd_data = s_r.rd_data;
	assign rd_last = s_r.rd_last;
	assign done = s_r.done;
	assign nack_err = s_r.err;
endmodule : srr_master

// ### test/srr_props.sv
// Protocol checks on the two-wire link between the two ends.
`timescale 1ns/1ps
module srr_props (
	input logic mclk,
	input logic rst_b,
	input logic scl,
	input logic sda,
	input logic sda_m_oe,
	input logic sda_s_oe
);
	logic [19:0] hi_r;
	logic [19:0] lo_r;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// Half a bit is 500 cycles; the window allows for counter phase.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			hi_r <= 20'h0;
			lo_r <= 20'h0;
		end else begin
			hi_r <= scl ? hi_r + 20'h1 : 20'h0;
			lo_r <= scl ? 20'h0 : lo_r + 20'h1;
		end
	end
	property p_scl_high;
		$fell(scl) |-> hi_r > 20'h1E0;
	endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("scl high phase too short");
	property p_scl_low;
		$rose(scl) |-> lo_r inside {[20'h1E0:20'h208]};
	endproperty
	a_scl_low: assert property (p_scl_low)
		else $error("scl low phase out of range");
	property p_sda_hold;
		$rose(scl) |=> $stable(sda) [*8];
	endproperty
	a_sda_hold: assert property (p_sda_hold)
		else $error("sda moved just after scl rise");
	property p_dev_edge;
		$changed(sda_s_oe) |-> !scl;
	endproperty
	a_dev_edge: assert property (p_dev_edge)
		else $error("device changed sda while scl high");
	property p_dev_steady;
		$fell(scl) |=> $stable(sda_s_oe) [*8];
	endproperty
	a_dev_steady: assert property (p_dev_steady)
		else $error("device sda not steady after scl fall");
	property p_no_fight;
		!(sda_m_oe && sda_s_oe);
	endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("both ends pull sda");
	property p_start;
		scl && $past(scl) && $fell(sda) |-> sda_m_oe && !sda_s_oe;
	endproperty
	a_start: assert property (p_start)
		else $error("start not made by master alone");
	property p_stop;
		scl && $past(scl) && $rose(sda) |-> !sda_m_oe && !sda_s_oe;
	endproperty
	a_stop: assert property (p_stop)
		else $error("line not released at stop");
	c_start: cover property (scl && $past(scl) && $fell(sda));
	c_dev_ack: cover property ($rose(scl) && sda_s_oe);
	c_mst_ack: cover property ($rose(scl) && sda_m_oe);
endmodule : srr_props

// ### test/srr_tb_top.sv
// Self-checking bench: master end talks to the device end over the link.
`timescale 1ns/1ps
module srr_tb_top;
	import srr_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b1;
	logic clk_en = 1'b1;
	logic cmd_valid = 1'b0;
	srr_op_t cmd_op = SRR_OP_PTR;
	logic [7:0] cmd_arg = 8'h00;
	logic cmd_ready, rd_valid, rd_last, done, nack_err, busy, active;
	logic [7:0] rd_data, reg_addr, blk_count;
	logic nack_seen = 1'b0;
	logic [7:0] got_q[$];
	logic last_q[$];
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	// Each location holds its own address xor 5A.
	wire [7:0] reg_data = reg_addr ^ 8'h5A;
	srr_link_if link();
	always #5 mclk = ~mclk;
	srr_master i_srr_master (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
		.link(link.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_arg(cmd_arg), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_last(rd_last), .done(done),
		.nack_err(nack_err), .busy(busy));
	srr_slave i_srr_slave (.link(link.slave), .rst_b(rst_b), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_data(reg_data), .blk_count(blk_count),
		.active(active));
	srr_props i_srr_props (.mclk(mclk), .rst_b(rst_b), .scl(link.scl),
		.sda(link.sda), .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s %h %h", $time, what, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s %b %b", $time, what, got, exp);
		end
	endtask : chk1
	// One command on the request port, then wait for its done pulse.
	task automatic run_cmd(input srr_op_t op, input logic [7:0] arg);
		int n;
		got_q.delete();
		last_q.delete();
		nack_seen = 1'b0;
		cmd_op = op;
		cmd_arg = arg;
		cmd_valid = 1'b1;
		@(posedge mclk);
		#1 cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 70000) begin
			@(posedge mclk);
			n++;
		end
		#1;
		if (n >= 70000) begin
			fail_count++;
			$display("CHECK FAILED %0t command timed out", $time);
			final_report();
		end
	endtask : run_cmd
	// The whole run is about 106k cycles, so the ceiling leaves a margin.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (rd_valid === 1'b1) begin
			got_q.push_back(rd_data);
			last_q.push_back(rd_last);
		end
		if (nack_err === 1'b1)
			nack_seen <= 1'b1;
		if (cyc == 130000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		// The drop makes an edge, so both ends leave the unknown state.
		#1 rst_b = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
		run_cmd(SRR_OP_PTR, 8'hFE);
		chk8(reg_addr, 8'hFE, "pointer");
		chk1(nack_seen, 1'b0, "pointer ack");
		$display("test pointer load ended");
		run_cmd(SRR_OP_RBYTE, 8'h00);
		chk8(8'(got_q.size()), 8'h01, "single size");
		chk8(got_q[0], 8'hA4, "single data");
		chk8(reg_addr, 8'hFE, "no advance");
		chk1(nack_seen, 1'b0, "single ack");
		chk1(link.sda_s_oe, 1'b0, "single release");
		$display("test single read ended");
		fork
			run_cmd(SRR_OP_RBLK, 8'h02);
			begin
				// Freeze both ends briefly while the clock is high.
				repeat (2600) @(posedge mclk);
				#1 clk_en = 1'b0;
				repeat (10) @(posedge mclk);
				#1 clk_en = 1'b1;
			end
		join
		chk8(8'(got_q.size()), 8'h02, "block size");
		chk8(got_q[0], 8'hA4, "block byte 0");
		chk8(got_q[1], 8'hA5, "block byte 1");
		chk1(last_q[0], 1'b0, "first not last");
		chk1(last_q[1], 1'b1, "last flagged");
		chk8(blk_count, 8'h02, "count byte");
		chk8(reg_addr, 8'h00, "pointer wrap");
		chk1(nack_seen, 1'b0, "block ack");
		chk1(link.sda_s_oe, 1'b0, "block release");
		chk1(active, 1'b0, "idle after block");
		$display("test block read ended");
		#1 rst_b = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
		chk8(reg_addr, SRR_PTR_RST, "reset pointer");
		chk8(blk_count, SRR_CNT_RST, "reset count");
		chk1(busy, 1'b0, "reset busy");
		chk1(cmd_ready, 1'b1, "reset ready");
		chk1(active, 1'b0, "reset active");
		chk1(link.scl, 1'b1, "reset clock");
		chk1(link.sda_s_oe, 1'b0, "reset release");
		$display("test mid-run reset ended");
		final_report();
	end
endmodule : srr_tb_top
